// ==== rtl/rwf_pkg.sv ====
// Package holding register map, field positions and sizes of the random generator
package rwf_pkg;
    // Register offsets on the device bus (12-bit device address)
    localparam logic [11:0] STATUS_OFFSET = 12'h600;
    localparam logic [11:0] OUTPUT_OFFSET = 12'h602;
    // Status field positions
    localparam int OUTPUT_READY_BIT = 18;
    localparam int RUNNING_BIT = 31;
    // Word width and shift register lengths
    localparam int WORD_W = 32;
    localparam int LINEAR_W = 43;
    localparam int AUTOMATA_W = 37;
    // Reset seeds of the two shift registers (non-zero so they never lock up)
    localparam logic [42:0] LINEAR_SEED = 43'h000_0000_0001;
    localparam logic [36:0] AUTOMATA_SEED = 37'h00_0000_0001;
    // Cycles the generator stirs after a read before a new word is ready
    localparam int STIR_CYCLES = 32;
    localparam logic [5:0] STIR_COUNT = 6'(STIR_CYCLES);
    // Read sequencer states
    typedef enum logic [1:0] {RWF_IDLE, RWF_WAIT, RWF_DONE} rwf_state_e;
endpackage : rwf_pkg

// ==== rtl/rwf_sequencer.sv ====
// Random generator register slave: status, output word and read wait states
`timescale 1ns/100ps

//////////////////////////////////////////////////////////////////////////////
// Behaviour
// - Ready flag bit 18 high when word fresh
// - Early output read stalled until ready
// - Bit 31 high while generator randomizing
// - Status at 0x600, output at 0x602
// - Ready flag halts shifting, read returns registers XORed into word
module rwf_sequencer #(
    parameter int STIR = rwf_pkg::STIR_CYCLES
) (
    // Clock and reset
    input wire logic clk,
    input wire logic resetn,
    // Generator enable from the front end
    input wire logic enable,
    // Device register bus, read only
    input wire logic [11:0] addr,
    input wire logic rd,
    // Read answer
    output logic [31:0] rdata,
    output logic ack,
    output logic wait_state,
    // Status levels
    output logic output_ready,
    output logic running
);
    logic [31:0] mix;
    logic [5:0] stir_cnt;
    logic halt;
    rwf_pkg::rwf_state_e state;
    logic out_sel;
    logic stat_sel;
    logic req;
    // Longest wait from a consumed word to the next ready flag, in cycles
    localparam int READY_LIMIT = STIR;

    //////////////////////////////////////////////////////////////////////////
    // Address decode
    always_comb begin
        stat_sel = 1'b0;
        out_sel = 1'b0;
        if (addr == rwf_pkg::STATUS_OFFSET) begin
            stat_sel = 1'b1;
        end else if (addr == rwf_pkg::OUTPUT_OFFSET) begin
            out_sel = 1'b1;
        end
    end

    // A read is taken only from idle and never in the cycle of an ack: the
    // master still holds its request on the edge at which it sees the answer,
    // and taking it again would answer one read twice
    assign req = rd && !ack && state == rwf_pkg::RWF_IDLE;

    // Shifting stops while a captured word is held or the generator is off
    assign halt = output_ready || !enable;

    rwf_shift_core #(
        .LW(rwf_pkg::LINEAR_W),
        .AW(rwf_pkg::AUTOMATA_W)
    ) u_core (
        .clk(clk),
        .resetn(resetn),
        .run(!halt),
        .mix(mix)
    );

    //////////////////////////////////////////////////////////////////////////
    // Stir counter: a word is only ready after enough fresh shifting
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            stir_cnt <= '0;
        end else if (!enable) begin
            stir_cnt <= '0;
        end else if (state == rwf_pkg::RWF_DONE) begin
            stir_cnt <= '0;
        end else if (!output_ready && stir_cnt != 6'(STIR)) begin
            stir_cnt <= stir_cnt + 6'd1;
        end
    end

    // Ready flag rises after stirring, drops when the word is consumed
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            output_ready <= 1'b0;
        end else if (!enable || state == rwf_pkg::RWF_DONE) begin
            output_ready <= 1'b0;
        end else if (stir_cnt == 6'(STIR) - 6'd1) begin
            output_ready <= 1'b1;
        end
    end

    // Running flag mirrors enable, one cycle late, from a flop
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            running <= 1'b0;
        end else begin
            running <= enable;
        end
    end

    //////////////////////////////////////////////////////////////////////////
    // Read sequencer: output reads wait for the ready flag
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            state <= rwf_pkg::RWF_IDLE;
        end else begin
            case (state)
                rwf_pkg::RWF_IDLE: begin
                    if (req && out_sel) begin
                        state <= output_ready ? rwf_pkg::RWF_DONE : rwf_pkg::RWF_WAIT;
                    end
                end
                rwf_pkg::RWF_WAIT: begin
                    if (output_ready) begin
                        state <= rwf_pkg::RWF_DONE;
                    end
                end
                default: begin
                    state <= rwf_pkg::RWF_IDLE;
                end
            endcase
        end
    end

    // Wait state is held from the stalled read until the edge that raises ack, one cycle after ready rises
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            wait_state <= 1'b0;
        end else begin
            wait_state <= (req && out_sel && !output_ready)
                || (state == rwf_pkg::RWF_WAIT && !output_ready);
        end
    end

    // Answer data and acknowledge; unmapped reads answer zero at once
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            rdata <= '0;
            ack <= 1'b0;
        end else begin
            ack <= 1'b0;
            rdata <= '0;
            if (req && !out_sel) begin
                ack <= 1'b1;
                if (stat_sel) begin
                    rdata[rwf_pkg::OUTPUT_READY_BIT] <= output_ready;
                    rdata[rwf_pkg::RUNNING_BIT] <= running;
                end
            end else if ((req && out_sel && output_ready)
                || (state == rwf_pkg::RWF_WAIT && output_ready)) begin
                ack <= 1'b1;
                rdata <= mix;
            end
        end
    end

    //////////////////////////////////////////////////////////////////////////
    // Checks
    sequence stalled_read_s;
        state == rwf_pkg::RWF_WAIT && !output_ready;
    endsequence

    sequence answer_s;
        ack;
    endsequence

    stall_ends_a: assert property (@(posedge clk) disable iff (!resetn)
        stalled_read_s ##1 output_ready |-> ##1 answer_s)
        else $error("stalled read not answered after ready");

    no_early_ack_a: assert property (@(posedge clk) disable iff (!resetn)
        (state == rwf_pkg::RWF_WAIT && !output_ready) |=> !ack)
        else $error("output read answered while not ready");

    wait_flag_a: assert property (@(posedge clk) disable iff (!resetn)
        stalled_read_s |=> wait_state)
        else $error("wait state missing during stall");

    ready_clears_a: assert property (@(posedge clk) disable iff (!resetn)
        state == rwf_pkg::RWF_DONE |=> !output_ready)
        else $error("ready flag not cleared after consumed read");

    running_a: assert property (@(posedge clk) disable iff (!resetn)
        running == $past(enable))
        else $error("running flag does not follow enable");

    status_bits_a: assert property (@(posedge clk) disable iff (!resetn)
        (req && stat_sel) |=>
        ack && rdata[rwf_pkg::RUNNING_BIT] == $past(running)
        && rdata[rwf_pkg::OUTPUT_READY_BIT] == $past(output_ready))
        else $error("status read returned wrong bits");

    halt_hold_a: assert property (@(posedge clk) disable iff (!resetn)
        output_ready && $past(output_ready) |-> $stable(mix))
        else $error("shift registers moved while word held");

    ready_time_a: assert property (@(posedge clk) disable iff (!resetn)
        $fell(output_ready) && enable |-> ##[1:READY_LIMIT] output_ready || !enable)
        else $error("ready flag did not return in time");

    // A held request must not be answered a second time
    single_ack_a: assert property (@(posedge clk) disable iff (!resetn)
        ack |=> !ack)
        else $error("one read answered twice");

    // Reads outside the two registers answer zero at once
    unmapped_zero_a: assert property (@(posedge clk) disable iff (!resetn)
        (req && !stat_sel && !out_sel) |=> ack && rdata == 32'h0)
        else $error("unmapped read not answered with zero");
endmodule : rwf_sequencer

// ==== rtl/rwf_shift_core.sv ====
// Linear and automata shift registers with halt control and XOR output mix
`timescale 1ns/100ps
module rwf_shift_core #(
    parameter int LW = 43,
    parameter int AW = 37
) (
    // Clock and reset
    input wire logic clk,
    input wire logic resetn,
    // Control
    input wire logic run,
    // Mixed output word
    output logic [31:0] mix
);
    logic [LW-1:0] linear_sr;
    logic [AW-1:0] automata_sr;
    logic [AW-1:0] next_automata;

    // Linear register advances only while running; halts while a word is held
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            linear_sr <= rwf_pkg::LINEAR_SEED;
        end else if (run) begin
            linear_sr <= {linear_sr[LW-2:0],
                linear_sr[LW-1] ^ linear_sr[LW-21] ^ linear_sr[LW-42]};
        end
    end

    // Rule 90/150 automaton, one cell per bit, null boundaries
    genvar g;
    generate
        for (g = 0; g < AW; g++) begin : g_cell
            logic left;
            logic right;
            assign left = (g == AW - 1) ? 1'b0 : automata_sr[(g + 1) % AW];
            assign right = (g == 0) ? 1'b0 : automata_sr[(g + AW - 1) % AW];
            // Cell 28 uses rule 150 to get maximal period
            if (g == 28) begin : g_150
                assign next_automata[g] = left ^ right ^ automata_sr[g];
            end else begin : g_90
                assign next_automata[g] = left ^ right;
            end
        end
    endgenerate

    // Automaton register advances alongside the linear one
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            automata_sr <= rwf_pkg::AUTOMATA_SEED;
        end else if (run) begin
            automata_sr <= next_automata;
        end
    end

    // Selected bits of both registers XORed into the word
    assign mix = linear_sr[31:0] ^ automata_sr[31:0];
endmodule : rwf_shift_core

// ==== tb/rwf_front_end_model.sv ====
// Bus front end model: polls status, drains random words, counts down
`timescale 1ns/100ps
module rwf_front_end_model (
    // Clock
    input wire logic clk,
    // Answer from the generator
    input wire logic [31:0] rdata,
    input wire logic ack,
    // Requests to the generator
    output logic [11:0] addr,
    output logic rd,
    // Fetch outcome
    output logic done
);
    logic [31:0] fifo_q[$];
    int unsigned words_left;
    int timeouts = 0;

    //////////////////////////////////////////////////////////////////////////
    // Bus idles with no request and no fetch finished
    initial begin
        addr = 12'h000;
        rd = 1'b0;
        done = 1'b0;
    end

    // Request held until one cycle after ack is seen; address lines scrambled once released
    task automatic read(input logic [11:0] a, output logic [31:0] d);
        int n;
        @(negedge clk);
        addr = a;
        rd = 1'b1;
        n = 0;
        while (ack !== 1'b1 && n < 200) begin
            @(negedge clk);
            n++;
        end
        if (ack !== 1'b1) timeouts++;
        d = rdata;
        @(negedge clk);
        rd = 1'b0;
        addr = ~a;
    endtask : read

    // Fetch loop; skipping the ready check provokes stalled reads on purpose
    task automatic fetch(input int unsigned count, input bit check);
        logic [31:0] w;
        words_left = count;
        done = 1'b0;
        while (words_left != 0) begin
            w = 32'h0;
            while (check && w[18] !== 1'b1) read(12'h600, w);
            read(12'h602, w);
            fifo_q.push_back(w);
            words_left--;
        end
        done = 1'b1;
    endtask : fetch
endmodule : rwf_front_end_model

// ==== tb/rwf_sequencer_test.sv ====
// Self-checking bench for the random word read sequencer
`timescale 1ns/100ps
module rwf_sequencer_test;
    localparam int STIR = 8; // Short stir, yet long enough for the first output read to stall
    logic clk = 1'b0;
    logic resetn = 1'b0;
    logic enable = 1'b0;
    logic [11:0] addr;
    logic rd;
    logic [31:0] rdata;
    logic ack;
    logic wait_state;
    logic output_ready;
    logic running;
    logic done;
    logic [31:0] w;
    logic [11:0] a;
    int num_errors = 0;
    int compares = 0;
    int stalls = 0;
    int n;
    `define CHECK(got, exp) begin compares++; if ((got) !== (exp)) begin num_errors++; \
        $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp); end end

    //////////////////////////////////////////////////////////////////////////
    // Clock, stall counter and units
    always #5 clk = ~clk;
    always @(negedge clk) if (wait_state === 1'b1) stalls++;

    rwf_sequencer #(.STIR(STIR)) uut (.clk(clk), .resetn(resetn), .enable(enable),
        .addr(addr), .rd(rd), .rdata(rdata), .ack(ack), .wait_state(wait_state),
        .output_ready(output_ready), .running(running));
    rwf_front_end_model fm (.clk(clk), .rdata(rdata), .ack(ack), .addr(addr), .rd(rd),
        .done(done));

    // Status word expected from the on and ready levels
    function automatic logic [31:0] status_exp(input logic on, input logic rdy);
        status_exp = 32'h0;
        status_exp[31] = on;
        status_exp[18] = rdy;
    endfunction : status_exp

    task automatic final_report();
        $display("compares=%0d num_errors=%0d", compares, num_errors);
        if (num_errors == 0 && compares > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : final_report

    // Watchdog sized well beyond the few hundred cycles the tests take
    initial begin
        #200000;
        num_errors++;
        final_report();
    end

    //////////////////////////////////////////////////////////////////////////
    // Main sequence
    initial begin
        void'($urandom(32'ha7e05134));
        repeat (6) @(negedge clk);
        resetn = 1'b1;
        fm.read(12'h600, w);
        `CHECK(w, status_exp(1'b0, 1'b0))
        enable = 1'b1;
        fm.read(12'h600, w);
        `CHECK(w, status_exp(1'b1, 1'b0))
        stalls = 0;
        fm.read(12'h602, w);
        `CHECK(stalls != 0, 1'b1)
        `CHECK(^w === 1'bx, 1'b0)
        `CHECK(output_ready, 1'b0)
        fm.read(12'h600, w);
        `CHECK(w, status_exp(1'b1, 1'b0))
        $display("test power and stall done");
        repeat (4) begin
            a = 12'($urandom);
            if (a == 12'h600 || a == 12'h602) a = a ^ 12'h001;
            fm.read(a, w);
            `CHECK(w, 32'h0)
        end
        $display("test unmapped done");
        repeat (3) begin
            n = 1 + int'($urandom % 4);
            stalls = 0;
            fm.fifo_q.delete();
            fm.fetch(n, 1'b1);
            `CHECK(fm.fifo_q.size(), n)
            `CHECK(stalls, 0)
            `CHECK(done, 1'b1)
            repeat (STIR + 2) @(negedge clk);
            fm.read(12'h600, w);
            `CHECK(w, status_exp(1'b1, 1'b1))
        end
        stalls = 0;
        fm.fifo_q.delete();
        fm.fetch(2, 1'b0);
        `CHECK(fm.fifo_q.size(), 2)
        `CHECK(stalls != 0, 1'b1)
        $display("test fetch done");
        enable = 1'b0;
        repeat (2) @(negedge clk);
        fm.read(12'h600, w);
        `CHECK(w[31], 1'b0)
        `CHECK(running, 1'b0)
        `CHECK(fm.timeouts, 0)
        $display("test power off done");
        final_report();
    end
endmodule : rwf_sequencer_test
